// [ahp_pkg.sv]
// Shared constants for the auto-format host write port
package ahp_pkg;

  localparam int unsigned ADDR_BITS      = 3;
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned WIDE_BITS      = 24;
  localparam int unsigned SYNC_STAGES    = 2;

  // Low three latched address bits select the target
  localparam logic [2:0] ADDR_TEMP0      = 3'h0;
  localparam logic [2:0] ADDR_TEMP1      = 3'h1;
  localparam logic [2:0] ADDR_TEMP2      = 3'h2;
  localparam logic [2:0] ADDR_CTRL_COMMIT = 3'h3;
  localparam logic [2:0] ADDR_INIT_COMMIT = 3'h4;

  // Values after reset
  localparam logic [7:0]  RST_TEMP       = 8'h00;
  localparam logic [23:0] RST_WIDE       = 24'h00_0000;
  localparam logic [2:0]  RST_ADDR       = 3'h0;
  localparam logic        RST_FMT_LATCH  = 1'b1;

  // One sample of the host pins
  typedef struct packed {
    logic [7:0] lines;
    logic       addrStrobe;
    logic       dataStrobe;
    logic       writeLine;
    logic       chipSelN;
  } ahp_pins_s;

  localparam ahp_pins_s RST_PINS = '{lines: 8'h00, addrStrobe: 1'b0, dataStrobe: 1'b1,
                                     writeLine: 1'b1, chipSelN: 1'b1};

endpackage : ahp_pkg

// [ahp_host_write_port.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Each rise of the address strobe samples the data/read strobe level as the bus format.
// - A high sample selects latch-pulse format, a low sample selects direction-line format.
// - The format is re-detected on every address strobe rise and may change each cycle of the bus.
// - Eight shared input-only lines carry the address and then the write data.
// - Writes are accepted only while the active-low chip select is asserted.
// - Address latch and data capture are timed by host strobe edges, not by device timing.
// - In latch-pulse format the address is latched on the falling edge of the latch strobe.
// - In latch-pulse format data is stored on the rising edge of the active-low write strobe.
// - In direction-line format the address is latched on the falling edge of the address strobe.
// - In direction-line format data is stored on the data strobe fall with direction and select low.
// - Addresses 0 to 2 load temporary bytes, 3 commits to control, 4 commits to initialisation.
// - Temporary bytes act only when a commit moves all three into a wide register at once.
module ahp_host_write_port
  import ahp_pkg::*;
(
  input  wire logic        clk,            // 40 MHz device clock
  input  wire logic        resetn,         // Asynchronous reset, active low
  input  wire logic [7:0]  sharedAddrDataLines, // Multiplexed address/data, input only
  input  wire logic        addrStrobeLine, // Address strobe / address latch enable
  input  wire logic        dataStrobeLine, // Data strobe / read strobe
  input  wire logic        writeLine,      // Direction line / active-low write strobe
  input  wire logic        chipSelN,       // Chip select, active low
  output logic [23:0]      controlReg,     // Committed control word
  output logic [23:0]      initReg,        // Committed initialisation word
  output logic             controlCommit,  // One-cycle pulse on control commit
  output logic             initCommit,     // One-cycle pulse on initialisation commit
  output logic             latchPulseFmt   // High while latch-pulse format is selected
);

  typedef struct packed {
    ahp_pins_s   sync1;
    ahp_pins_s   sync2;
    ahp_pins_s   prev;
    logic        fmtLatch;
    logic [2:0]  addr;
    logic [7:0]  temp0;
    logic [7:0]  temp1;
    logic [7:0]  temp2;
    logic [23:0] ctrl;
    logic [23:0] init;
    logic        ctrlPulse;
    logic        initPulse;
  } ahp_state_s;

  ahp_state_s state_r;
  ahp_state_s state_nxt;
  ahp_pins_s  pinsIn;

  assign pinsIn = '{lines: sharedAddrDataLines, addrStrobe: addrStrobeLine,
                    dataStrobe: dataStrobeLine, writeLine: writeLine, chipSelN: chipSelN};

  always_comb begin
    logic asRise;
    logic asFall;
    logic wrRise;
    logic dsFall;
    logic doWrite;
    asRise  = 1'b0;
    asFall  = 1'b0;
    wrRise  = 1'b0;
    dsFall  = 1'b0;
    doWrite = 1'b0;
    state_nxt = state_r;
    // Data travels through the same stages as the strobes, so a short hold time still
    // lines up with the edge seen two cycles later
    state_nxt.sync1 = pinsIn;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.prev  = state_r.sync2;
    state_nxt.ctrlPulse = 1'b0;
    state_nxt.initPulse = 1'b0;

    // Edges come only from host strobe transitions
    asRise = state_r.sync2.addrStrobe && !state_r.prev.addrStrobe;
    asFall = !state_r.sync2.addrStrobe && state_r.prev.addrStrobe;
    wrRise = state_r.sync2.writeLine && !state_r.prev.writeLine;
    dsFall = !state_r.sync2.dataStrobe && state_r.prev.dataStrobe;

    if (asRise) begin
      state_nxt.fmtLatch = state_r.sync2.dataStrobe;
    end
    if (asFall) begin
      state_nxt.addr = state_r.sync2.lines[2:0];
    end

    if (state_r.fmtLatch) begin
      // Read strobe level matters only for detection here
      doWrite = wrRise && !state_r.sync2.chipSelN;
    end else begin
      doWrite = dsFall && !state_r.sync2.writeLine
                && !state_r.sync2.chipSelN;
    end

    if (doWrite) begin
      unique case (state_r.addr)
        ADDR_TEMP0: state_nxt.temp0 = state_r.sync2.lines;
        ADDR_TEMP1: state_nxt.temp1 = state_r.sync2.lines;
        ADDR_TEMP2: state_nxt.temp2 = state_r.sync2.lines;
        ADDR_CTRL_COMMIT: begin
          state_nxt.ctrl = {state_r.temp2, state_r.temp1, state_r.temp0};
          state_nxt.ctrlPulse = 1'b1;
        end
        ADDR_INIT_COMMIT: begin
          state_nxt.init = {state_r.temp2, state_r.temp1, state_r.temp0};
          state_nxt.initPulse = 1'b1;
        end
        // Addresses 5 to 7 are unused and writes to them are dropped
        default: state_nxt.temp0 = state_r.temp0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r.sync1     <= RST_PINS;
      state_r.sync2     <= RST_PINS;
      state_r.prev      <= RST_PINS;
      state_r.fmtLatch  <= RST_FMT_LATCH;
      state_r.addr      <= RST_ADDR;
      state_r.temp0     <= RST_TEMP;
      state_r.temp1     <= RST_TEMP;
      state_r.temp2     <= RST_TEMP;
      state_r.ctrl      <= RST_WIDE;
      state_r.init      <= RST_WIDE;
      state_r.ctrlPulse <= 1'b0;
      state_r.initPulse <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign controlReg    = state_r.ctrl;
  assign initReg       = state_r.init;
  assign controlCommit = state_r.ctrlPulse;
  assign initCommit    = state_r.initPulse;
  assign latchPulseFmt = state_r.fmtLatch;

endmodule // ahp_host_write_port

`default_nettype wire

// [ahp_host_write_port_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ahp_asserts (
  input wire logic        clk,            // Clock
  input wire logic        resetn,         // Reset
  input wire logic        addrStrobeLine, // Strobe
  input wire logic        dataStrobeLine, // Strobe
  input wire logic        chipSelN,       // Select
  input wire logic [23:0] controlReg,     // Word
  input wire logic [23:0] initReg,        // Word
  input wire logic        controlCommit,  // Pulse
  input wire logic        initCommit,     // Pulse
  input wire logic        latchPulseFmt   // Format
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_fmt_high: assert property ($rose(addrStrobeLine) && dataStrobeLine
    |-> ##[2:5] latchPulseFmt) else $error("format high");
  a_fmt_low: assert property ($rose(addrStrobeLine) && !dataStrobeLine
    |-> ##[2:5] !latchPulseFmt) else $error("format low");
  a_ctl_pulse: assert property (controlCommit |=> !controlCommit) else $error("ctl");
  a_ini_pulse: assert property (initCommit |=> !initCommit) else $error("init");
  a_ctl_held: assert property ($changed(controlReg) |-> controlCommit) else $error("c");
  a_ini_held: assert property ($changed(initReg) |-> initCommit) else $error("i");
  a_commit_sel: assert property ((controlCommit || initCommit) |-> !$past(chipSelN, 3))
    else $error("select");
  a_one_target: assert property (!(controlCommit && initCommit)) else $error("both");
endmodule // ahp_asserts
bind ahp_host_write_port ahp_asserts u_ahp_asserts (.*);
`default_nettype wire

// [ahp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ahp_host_model (
  input  wire logic       clk,        // Clock
  output var  logic [7:0] lines,      // Shared lines
  output var  logic       addrStrobe, // Address strobe
  output var  logic       dataStrobe, // Data or read strobe
  output var  logic       writeSel,   // Direction or write strobe
  output var  logic       chipSelN    // Select
);
  initial {lines, addrStrobe, dataStrobe, writeSel, chipSelN} = 12'h007;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Lines left holding the inverse byte so stale data is never taken as valid
  // A set r makes it a read cycle: direction line stays high, no write strobe edge
  task automatic wr(input bit m, c, r, input logic [7:0] a, d);
    dataStrobe = m;
    step(3);
    {addrStrobe, lines} = {1'b1, a};
    step(4);
    addrStrobe = 0;
    step(4);
    {chipSelN, lines, writeSel, dataStrobe} = {c, d, r, 1'b1};
    step(4);
    if (m && !r) writeSel = 1;
    else dataStrobe = 0;
    step(4);
    {chipSelN, lines, writeSel} = {1'b1, ~d, 1'b1};
    step(2);
  endtask
endmodule // ahp_host_model
`default_nettype wire

// [ahp_host_write_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module ahp_host_write_port_test;
  import ahp_pkg::*;
  logic        clk, resetn, as, ds, ws, csN, ctlP, iniP, fmt;
  logic [7:0]  lines, a, d;
  logic [7:0]  tmp [3];
  logic [23:0] ctl, ini, eCtl, eIni;
  int          errors, testsRun, cyc, nC, nI, eC, eI;
  bit          m, c, r;
  ahp_host_model u_ahp_host_model (.clk(clk), .lines(lines), .addrStrobe(as),
    .dataStrobe(ds), .writeSel(ws), .chipSelN(csN));
  ahp_host_write_port u_ahp_host_write_port (.clk(clk), .resetn(resetn),
    .sharedAddrDataLines(lines), .addrStrobeLine(as), .dataStrobeLine(ds), .writeLine(ws),
    .chipSelN(csN), .controlReg(ctl), .initReg(ini), .controlCommit(ctlP),
    .initCommit(iniP), .latchPulseFmt(fmt));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, e);
    testsRun++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d tests %0d", errors, testsRun);
    if (errors == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    nC += (ctlP === 1'b1);
    nI += (iniP === 1'b1);
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    resetn = 0;
    tmp = '{default: 8'h00};
    {eCtl, eIni} = 0;
    void'($urandom(87495));
    repeat (5) @(posedge clk);
    #2 resetn = 1;
    chk(fmt, 1);
    for (int i = 0; i < 48; i++) begin
      {m, c, a, d} = {1'($urandom), $urandom % 5 == 0, 8'($urandom), 8'($urandom)};
      a[2:0] = 3'(i);
      r = ($urandom % 5 == 1);
      u_ahp_host_model.wr(m, c, r, a, d);
      if (!c && !r && a[2:0] < 3) tmp[a[2:0]] = d;
      if (!c && !r && a[2:0] == ADDR_CTRL_COMMIT) {eC, eCtl} = {eC + 1, tmp[2], tmp[1], tmp[0]};
      if (!c && !r && a[2:0] == ADDR_INIT_COMMIT) {eI, eIni} = {eI + 1, tmp[2], tmp[1], tmp[0]};
      chk(fmt, m);
      chk(ctl, eCtl);
      chk(ini, eIni);
      chk(nC * 256 + nI, eC * 256 + eI);
      $display("test %0d done", i);
    end
    wrap_up();
  end
endmodule // ahp_host_write_port_test
`default_nettype wire
